// ==== core/usdb_top.sv ====
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: All sixteen shadow words reach the same receive and transmit data.
// R02: Shadow read returns byte from serial or infrared receiver by mode.
// R03: Byte is valid only while line state receive valid flag is set.
// R04: FIFO off: new byte overwrites unread byte and raises overrun.
// R05: FIFO on: a shadow read returns and removes the receive FIFO head.
// R06: Full receive FIFO keeps entries, drops new byte, raises overrun.
// R07: Shadow write queues byte for serial or infrared transmitter by mode.
// R08: Software writes transmit data only while holding empty flag is set.
// R09: FIFO off: one written byte clears the holding empty flag.
// R10: FIFO off: further writes before empty overwrite the pending byte.
// R11: FIFO on: writes are accepted until the sixteen-entry FIFO is full.
// R12: Writes while the transmit FIFO is full are dropped unchanged.
// R13: Reserved upper shadow bits read zero and ignore writes.
module usdb_top
    import usdb_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic [7:0] RX_UART_BYTE,
    input wire logic RX_UART_STB,
    input wire logic [7:0] RX_IR_BYTE,
    input wire logic RX_IR_STB,
    output logic [7:0] TX_BYTE,
    output logic TX_UART_VALID,
    output logic TX_IR_VALID,
    input wire logic TX_TAKE,
    output logic IRQ
);
    import usdb_pkg::*;

    // ============================================================
    // Address decode
    function automatic logic is_shadow(input logic [31:0] addr);
        logic [31:0] off;
        off = addr - SHADOW_BASE_ADDR;
        return (addr >= SHADOW_BASE_ADDR) && (off < SHADOW_SPAN) &&
               (addr[1:0] == WORD_ALIGN);
    endfunction : is_shadow

    // ============================================================
    // State
    logic fifo_en_q, fifo_en_d;
    logic mode_ir_q, mode_ir_d;
    logic [7:0] rx_hold_q, rx_hold_d;
    logic rx_valid_q, rx_valid_d;
    logic overrun_q, overrun_d;
    usdb_tx_state_type tx_state_q, tx_state_d;
    logic [7:0] tx_byte_q, tx_byte_d;
    logic tx_uart_valid_q, tx_uart_valid_d;
    logic tx_ir_valid_q, tx_ir_valid_d;
    logic tx_holding_empty_flag_prev_q, tx_holding_empty_flag_prev_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0] irq_en_q, irq_en_d;
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;

    // ============================================================
    // Working signals
    logic wr_shadow;
    logic rd_shadow;
    logic rd_line;
    logic rx_stb;
    logic [7:0] rx_byte;
    logic rx_data_valid;
    logic [7:0] rx_read_byte;
    logic overrun_ev;
    logic tx_empty_flag;
    logic tx_holding_empty_flag_now;
    logic flush;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    logic [31:0] line_word;

    usdb_fifo_if rx_q ();
    usdb_fifo_if tx_q ();

    usdb_fifo u_rx_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .q(rx_q.store)
    );

    usdb_fifo u_tx_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .q(tx_q.store)
    );

    // ============================================================
    // Next-state logic
    always_comb begin
        fifo_en_d = fifo_en_q;
        mode_ir_d = mode_ir_q;
        rx_hold_d = rx_hold_q;
        rx_valid_d = rx_valid_q;
        tx_state_d = tx_state_q;
        tx_byte_d = tx_byte_q;
        irq_en_d = irq_en_q;
        flush = 1'b0;
        overrun_ev = 1'b0;
        irq_clr = IRQ_RESET;
        rdata_d = WORD_ZERO;

        wr_shadow = REG_WR && is_shadow(REG_ADDR); // see R01
        rd_shadow = REG_RD && is_shadow(REG_ADDR); // see R01
        rd_line = REG_RD && (REG_ADDR == LINE_STATE_ADDR);

        // Receiver source follows the link mode
        rx_stb = mode_ir_q ? RX_IR_STB : RX_UART_STB; // see R02
        rx_byte = mode_ir_q ? RX_IR_BYTE : RX_UART_BYTE; // see R02

        // Control writes; a change of FIFO mode empties both queues
        if (REG_WR) begin
            case (REG_ADDR)
                FIFO_CTRL_ADDR: begin
                    fifo_en_d = REG_WDATA[FCR_FIFO_EN_BIT];
                    flush = (REG_WDATA[FCR_FIFO_EN_BIT] != fifo_en_q);
                end
                MODE_CTRL_ADDR: begin
                    mode_ir_d = REG_WDATA[MODE_IR_BIT];
                end
                IRQ_CLEAR_ADDR: begin
                    irq_clr = REG_WDATA[IRQ_W-1:0];
                end
                IRQ_ENABLE_ADDR: begin
                    irq_en_d = REG_WDATA[IRQ_W-1:0];
                end
                default: begin
                    irq_clr = IRQ_RESET;
                end
            endcase
        end

        // ========================================================
        // Receive path
        rx_q.push = fifo_en_q && rx_stb; // see R05
        rx_q.push_data = rx_byte;
        rx_q.pop = fifo_en_q && rd_shadow; // see R05
        rx_q.flush = flush;
        if (flush) begin
            rx_valid_d = 1'b0;
        end else if (!fifo_en_q) begin
            if (rx_stb) begin
                rx_hold_d = rx_byte; // see R04
                rx_valid_d = 1'b1;
                overrun_ev = rx_valid_q && !rd_shadow; // see R04
            end else if (rd_shadow) begin
                rx_valid_d = 1'b0;
            end
        end else begin
            overrun_ev = rx_stb && !rx_q.push_ok; // see R06
        end
        rx_data_valid = fifo_en_q ? !rx_q.empty : rx_valid_q; // see R03
        rx_read_byte = fifo_en_q ? rx_q.head : rx_hold_q; // see R05

        // ========================================================
        // Transmit path
        tx_q.push = fifo_en_q && wr_shadow; // see R11
        tx_q.push_data = REG_WDATA[7:0]; // see R13
        tx_q.pop = 1'b0;
        tx_q.flush = flush;
        if (!fifo_en_q) begin
            if (wr_shadow) begin
                // Holding slot is replaced even while pending
                tx_byte_d = REG_WDATA[7:0]; // see R10
                tx_state_d = TX_PEND; // see R09
            end else if (TX_TAKE && (tx_state_q == TX_PEND)) begin
                tx_state_d = TX_IDLE;
            end
        end else begin
            if ((tx_state_q == TX_IDLE) || TX_TAKE) begin
                if (!tx_q.empty && !flush) begin
                    tx_q.pop = 1'b1;
                    tx_byte_d = tx_q.head;
                    tx_state_d = TX_PEND;
                end else begin
                    tx_state_d = TX_IDLE;
                end
            end
        end
        // Full FIFO silently drops the write inside the queue
        tx_empty_flag = fifo_en_q ? tx_q.empty :
                        (tx_state_q == TX_IDLE); // see R09
        tx_holding_empty_flag_now = tx_empty_flag; // see R08
        tx_holding_empty_flag_prev_d = tx_holding_empty_flag_now;
        tx_uart_valid_d = (tx_state_d == TX_PEND) && !mode_ir_d; // see R07
        tx_ir_valid_d = (tx_state_d == TX_PEND) && mode_ir_d; // see R07

        // ========================================================
        // Line state and interrupts; a new event beats a clear
        overrun_d = overrun_ev || (overrun_q && !rd_line);
        irq_ev = IRQ_RESET;
        irq_ev[IRQ_RX_BIT] = rx_stb;
        irq_ev[IRQ_OVR_BIT] = overrun_ev;
        irq_ev[IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag_now && !tx_holding_empty_flag_prev_q;
        irq_stat_d = irq_ev | (irq_stat_q & ~irq_clr);
        irq_d = |(irq_stat_d & irq_en_d);

        line_word = WORD_ZERO;
        line_word[LSR_DR_BIT] = rx_data_valid; // see R03
        line_word[LSR_OE_BIT] = overrun_q;
        line_word[LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag_now; // see R09

        // ========================================================
        // Read data, valid in the cycle after the strobe only
        if (REG_RD) begin
            if (rd_shadow) begin
                rdata_d = {UPPER_ZERO, rx_read_byte}; // see R13
            end else begin
                case (REG_ADDR)
                    FIFO_CTRL_ADDR: begin
                        rdata_d[FCR_FIFO_EN_BIT] = fifo_en_q;
                    end
                    MODE_CTRL_ADDR: begin
                        rdata_d[MODE_IR_BIT] = mode_ir_q;
                    end
                    LINE_STATE_ADDR: begin
                        rdata_d = line_word;
                    end
                    IRQ_STATUS_ADDR: begin
                        rdata_d[IRQ_W-1:0] = irq_stat_q;
                    end
                    IRQ_ENABLE_ADDR: begin
                        rdata_d[IRQ_W-1:0] = irq_en_q;
                    end
                    default: begin
                        rdata_d = WORD_ZERO;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fifo_en_q <= 1'b0;
            mode_ir_q <= 1'b0;
            rx_hold_q <= BYTE_RESET;
            rx_valid_q <= 1'b0;
            overrun_q <= 1'b0;
            tx_state_q <= TX_IDLE;
            tx_byte_q <= BYTE_RESET;
            tx_uart_valid_q <= 1'b0;
            tx_ir_valid_q <= 1'b0;
            tx_holding_empty_flag_prev_q <= 1'b1;
            irq_stat_q <= IRQ_RESET;
            irq_en_q <= IRQ_RESET;
            irq_q <= 1'b0;
            rdata_q <= WORD_ZERO;
        end else begin
            fifo_en_q <= fifo_en_d;
            mode_ir_q <= mode_ir_d;
            rx_hold_q <= rx_hold_d;
            rx_valid_q <= rx_valid_d;
            overrun_q <= overrun_d;
            tx_state_q <= tx_state_d;
            tx_byte_q <= tx_byte_d;
            tx_uart_valid_q <= tx_uart_valid_d;
            tx_ir_valid_q <= tx_ir_valid_d;
            tx_holding_empty_flag_prev_q <= tx_holding_empty_flag_prev_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign TX_BYTE = tx_byte_q;
    assign TX_UART_VALID = tx_uart_valid_q;
    assign TX_IR_VALID = tx_ir_valid_q;
    assign IRQ = irq_q;
endmodule : usdb_top
`default_nettype wire

// ==== shared/usdb_pkg.sv ====
`default_nettype none
// ============================================================
// Shared constants for the shadow data buffer
package usdb_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned IRQ_W = 3;

    // ============================================================
    // Shadow word array: sixteen aligned 32-bit locations
    localparam logic [31:0] SHADOW_BASE_ADDR = 32'h50001030;
    localparam logic [31:0] SHADOW12_ADDR = 32'h50001060;
    localparam logic [31:0] SHADOW13_ADDR = 32'h50001064;
    localparam logic [31:0] SHADOW_SPAN = 32'h00000040;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ============================================================
    // Control and status registers of the block
    localparam logic [31:0] FIFO_CTRL_ADDR = 32'h50001100;
    localparam logic [31:0] MODE_CTRL_ADDR = 32'h50001104;
    localparam logic [31:0] LINE_STATE_ADDR = 32'h50001108;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000110c;
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h50001110;
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h50001114;

    // ============================================================
    // Field positions
    localparam int unsigned FCR_FIFO_EN_BIT = 0;
    localparam int unsigned MODE_IR_BIT = 0;
    localparam int unsigned LSR_DR_BIT = 0;
    localparam int unsigned LSR_OE_BIT = 1;
    localparam int unsigned LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam int unsigned IRQ_RX_BIT = 0;
    localparam int unsigned IRQ_OVR_BIT = 1;
    localparam int unsigned IRQ_TX_HOLDING_EMPTY_FLAG_BIT = 2;

    // ============================================================
    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_PEND = 2'b10
    } usdb_tx_state_type;
endpackage : usdb_pkg
`default_nettype wire

// ==== shared/usdb_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Byte queue connection between the buffer logic and a FIFO
interface usdb_fifo_if;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic flush;
    logic [7:0] head;
    logic full;
    logic empty;
    logic push_ok;
    modport store(input push, input push_data, input pop, input flush,
                  output head, output full, output empty, output push_ok);
    modport user(output push, output push_data, output pop, output flush,
                 input head, input full, input empty, input push_ok);
endinterface : usdb_fifo_if
`default_nettype wire

// ==== core/usdb_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Sixteen-entry byte FIFO in flip-flops
module usdb_fifo
    import usdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    usdb_fifo_if.store q
);
    logic [7:0] mem_q [FIFO_DEPTH];
    logic [7:0] mem_d [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic pop_ok;
    logic push_ok;

    assign q.head = mem_q[rd_ptr_q];
    assign q.full = (cnt_q == CNT_FULL); // see R06 R12
    assign q.empty = (cnt_q == CNT_RESET);
    assign q.push_ok = push_ok;

    always_comb begin
        mem_d = mem_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        cnt_d = cnt_q;
        pop_ok = q.pop && (cnt_q != CNT_RESET) && !q.flush;
        // A full queue drops the push unless a pop frees a slot
        push_ok = q.push && !q.flush && ((cnt_q != CNT_FULL) || pop_ok);
        if (q.flush) begin
            wr_ptr_d = PTR_RESET;
            rd_ptr_d = PTR_RESET;
            cnt_d = CNT_RESET;
        end else begin
            if (push_ok) begin
                mem_d[wr_ptr_q] = q.push_data;
                wr_ptr_d = wr_ptr_q + PTR_ONE;
            end
            if (pop_ok) begin
                rd_ptr_d = rd_ptr_q + PTR_ONE;
            end
            if (push_ok && !pop_ok) begin
                cnt_d = cnt_q + CNT_ONE;
            end else if (pop_ok && !push_ok) begin
                cnt_d = cnt_q - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_q[i] <= BYTE_RESET;
            end
            wr_ptr_q <= PTR_RESET;
            rd_ptr_q <= PTR_RESET;
            cnt_q <= CNT_RESET;
        end else begin
            mem_q <= mem_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : usdb_fifo
`default_nettype wire

// ==== verif/usdb_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the shadow data buffer
module usdb_checker
    import usdb_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [7:0] RX_UART_BYTE,
    input wire logic RX_UART_STB,
    input wire logic [7:0] RX_IR_BYTE,
    input wire logic RX_IR_STB,
    input wire logic [7:0] TX_BYTE,
    input wire logic TX_UART_VALID,
    input wire logic TX_IR_VALID,
    input wire logic TX_TAKE,
    input wire logic IRQ
);
    logic fifo_on_q, fifo_on_d, ir_q, ir_d, is_sh, tx_v;
    assign is_sh = REG_ADDR >= SHADOW_BASE_ADDR && REG_ADDR[1:0] == WORD_ALIGN
        && REG_ADDR < SHADOW_BASE_ADDR + SHADOW_SPAN;
    assign tx_v = TX_UART_VALID || TX_IR_VALID;
    // ============================================================
    // Mirror of the mode bits set by software
    always_comb begin
        fifo_on_d = fifo_on_q;
        ir_d = ir_q;
        if (REG_WR && REG_ADDR == FIFO_CTRL_ADDR) begin
            fifo_on_d = REG_WDATA[FCR_FIFO_EN_BIT];
        end
        if (REG_WR && REG_ADDR == MODE_CTRL_ADDR) begin
            ir_d = REG_WDATA[MODE_IR_BIT];
        end
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fifo_on_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            fifo_on_q <= fifo_on_d;
            ir_q <= ir_d;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_arrive;
        !fifo_on_q && !ir_q && RX_UART_STB && !REG_RD;
    endsequence
    sequence s_quiet;
        !RX_UART_STB && !REG_RD && !REG_WR;
    endsequence
    sequence s_read_ls;
        REG_RD && REG_ADDR == LINE_STATE_ADDR;
    endsequence
    chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == WORD_ZERO)
        else $error("read data not zero outside a read");
    chk_upper_zero: assert property (REG_RD && is_sh |=> REG_RDATA[31:8] == UPPER_ZERO)
        else $error("reserved shadow bits not zero");
    chk_rd_byte: assert property (s_arrive ##1 s_quiet ##1 (REG_RD && is_sh)
        |=> REG_RDATA == {UPPER_ZERO, $past(RX_UART_BYTE, 3)})
        else $error("shadow read lost the received byte");
    chk_rd_flag: assert property (s_arrive ##1 s_quiet ##1 s_read_ls
        |=> REG_RDATA[LSR_DR_BIT])
        else $error("receive valid flag not set");
    chk_overrun_flag: assert property (s_arrive ##1 s_quiet ##1 s_arrive
        ##1 s_quiet ##1 s_read_ls |=> REG_RDATA[LSR_OE_BIT])
        else $error("overrun not flagged");
    chk_wr_direct: assert property (!fifo_on_q && REG_WR && is_sh && !TX_TAKE
        |=> (ir_q ? TX_IR_VALID : TX_UART_VALID) && TX_BYTE == $past(REG_WDATA[7:0]))
        else $error("direct write not pending");
    chk_fifo_lat: assert property (fifo_on_q && REG_WR && is_sh && !tx_v
        && !$past(REG_WR) |-> ##2 tx_v && TX_BYTE == $past(REG_WDATA[7:0], 2))
        else $error("queued byte not presented");
    chk_take_clears: assert property (!fifo_on_q && TX_TAKE && tx_v && !REG_WR
        |=> !tx_v)
        else $error("pending byte not consumed");
    chk_byte_hold: assert property (tx_v && !TX_TAKE && !REG_WR
        |=> TX_BYTE == $past(TX_BYTE))
        else $error("pending byte changed");
endmodule : usdb_checker
`default_nettype wire

// ==== verif/usdb_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Serial and infrared line side: byte source and transmit sink
module usdb_line_model (
    input wire logic clk,
    input wire logic uart_valid,
    input wire logic ir_valid,
    input wire logic [7:0] tx_byte,
    input wire logic take_en,
    output logic tx_take,
    output logic [7:0] rx_uart_byte,
    output logic rx_uart_stb,
    output logic [7:0] rx_ir_byte,
    output logic rx_ir_stb
);
    logic [8:0] got[$];
    initial begin
        tx_take = 1'b0;
        rx_uart_stb = 1'b0;
        rx_ir_stb = 1'b0;
        rx_uart_byte = 8'h00;
        rx_ir_byte = 8'h00;
    end
    // Idle data lines show the inverse so stale bytes never match
    task automatic send(input logic [7:0] b, input logic ir);
        @(posedge clk);
        if (ir) begin
            rx_ir_byte <= b;
            rx_ir_stb <= 1'b1;
        end else begin
            rx_uart_byte <= b;
            rx_uart_stb <= 1'b1;
        end
        @(posedge clk);
        rx_uart_stb <= 1'b0;
        rx_ir_stb <= 1'b0;
        rx_uart_byte <= ~b;
        rx_ir_byte <= ~b;
    endtask : send
    // Takes at most every other cycle; take_en low stalls the line
    always @(posedge clk) begin
        tx_take <= 1'b0;
        if (take_en && (uart_valid || ir_valid) && !tx_take) begin
            tx_take <= 1'b1;
            got.push_back({ir_valid, tx_byte});
        end
    end
endmodule : usdb_line_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usdb_pkg::*;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic clk, rst, wr, rd, take, tx_take, uv, iv, irq, ustb, istb;
    logic [31:0] addr, wdata, rdata, v;
    logic [7:0] ub, ib, txb;
    int n_fail, n_checks, cyc, k;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    usdb_top i_dut(.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_UART_BYTE(ub),
        .RX_UART_STB(ustb), .RX_IR_BYTE(ib), .RX_IR_STB(istb), .TX_BYTE(txb),
        .TX_UART_VALID(uv), .TX_IR_VALID(iv), .TX_TAKE(tx_take), .IRQ(irq));
    usdb_line_model i_line(.clk(clk), .uart_valid(uv), .ir_valid(iv),
        .tx_byte(txb), .take_en(take), .tx_take(tx_take), .rx_uart_byte(ub),
        .rx_uart_stb(ustb), .rx_ir_byte(ib), .rx_ir_stb(istb));
    // ============================================================
    // Bus access and comparison
    task automatic check(input string n, input logic [31:0] got,
                         input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask : check
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rc(input string n, input logic [31:0] a,
                      input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        check(n, v & m, exp);
    endtask : rc
    task automatic wait_idle;
        // Let the written byte reach the output before polling for idle
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 200 && (uv || iv); i++) begin
            @(posedge clk);
            #1;
        end
        check("tx idle", {30'h0, uv, iv}, 32'h0);
    endtask : wait_idle
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ============================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        take = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rc("line state", LINE_STATE_ADDR, 32'h23, 32'h20);
        rc("shadow reset", SHADOW12_ADDR, ALL, 32'h0);
        rc("unmapped", 32'h50001200, ALL, 32'h0);
        i_line.send(8'h55, 1'b0);
        rc("rx byte", SHADOW12_ADDR, ALL, 32'h55);
        rc("rx valid off", LINE_STATE_ADDR, 32'h1, 32'h0);
        i_line.send(8'ha1, 1'b0);
        i_line.send(8'hb2, 1'b0);
        rc("overrun", LINE_STATE_ADDR, 32'h3, 32'h3);
        rc("newest byte", SHADOW13_ADDR, ALL, 32'hb2);
        wr_reg(MODE_CTRL_ADDR, 32'h1);
        i_line.send(8'h3c, 1'b1);
        rc("ir byte", SHADOW_BASE_ADDR, ALL, 32'h3c);
        wr_reg(SHADOW12_ADDR, 32'hffffff5a);
        wait_idle();
        check("ir tx", {23'h0, i_line.got.pop_front()}, 32'h15a);
        wr_reg(MODE_CTRL_ADDR, 32'h0);
        take <= 1'b0;
        wr_reg(SHADOW12_ADDR, 32'h41);
        rc("holding full", LINE_STATE_ADDR, 32'h20, 32'h0);
        wr_reg(SHADOW13_ADDR, 32'h42);
        take <= 1'b1;
        wait_idle();
        check("tx overwrite", {23'h0, i_line.got.pop_front()}, 32'h42);
        check("tx count", 32'(i_line.got.size()), 32'h0);
        rc("holding empty", LINE_STATE_ADDR, 32'h20, 32'h20);
        wr_reg(FIFO_CTRL_ADDR, 32'h1);
        for (k = 0; k < 17; k++) i_line.send(8'h10 + 8'(k), 1'b0);
        rc("rx overrun", LINE_STATE_ADDR, 32'h2, 32'h2);
        for (k = 0; k < 16; k++) begin
            rc("rx head", SHADOW_BASE_ADDR + 32'(k * 4), ALL, 32'h10 + 32'(k));
        end
        rc("rx drained", LINE_STATE_ADDR, 32'h1, 32'h0);
        take <= 1'b0;
        for (k = 0; k < 18; k++) begin
            wr_reg(SHADOW_BASE_ADDR + 32'((k % 16) * 4), 32'h60 + 32'(k));
        end
        take <= 1'b1;
        wait_idle();
        check("tx queued", 32'(i_line.got.size()), 32'h11);
        for (k = 0; k < 17; k++) begin
            check("tx order", {23'h0, i_line.got.pop_front()}, 32'h60 + 32'(k));
        end
        wr_reg(IRQ_CLEAR_ADDR, 32'h7);
        wr_reg(IRQ_ENABLE_ADDR, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check("irq idle", {31'h0, irq}, 32'h0);
        i_line.send(8'h77, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        check("irq raised", {31'h0, irq}, 32'h1);
        rc("irq status", IRQ_STATUS_ADDR, 32'h1, 32'h1);
        wr_reg(IRQ_ENABLE_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        check("irq masked", {31'h0, irq}, 32'h0);
        wr_reg(IRQ_CLEAR_ADDR, 32'h1);
        wr_reg(IRQ_ENABLE_ADDR, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0);
        rc("rx fifo", SHADOW13_ADDR, ALL, 32'h77);
        give_verdict();
    end
endmodule : tb
bind usdb_top usdb_checker i_chk(.CLK(CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_UART_BYTE(RX_UART_BYTE),
    .RX_UART_STB(RX_UART_STB), .RX_IR_BYTE(RX_IR_BYTE), .RX_IR_STB(RX_IR_STB),
    .TX_BYTE(TX_BYTE), .TX_UART_VALID(TX_UART_VALID),
    .TX_IR_VALID(TX_IR_VALID), .TX_TAKE(TX_TAKE), .IRQ(IRQ));
`default_nettype wire
